// File: sbac_map.svh
/*
  named offsets, field positions, reset values and timing counts for the
  system-bus agent side controller (host side of the processor bus).
  assumes: included by its bare name; definitions only.
*/
`ifndef SBAC_MAP_SVH
`define SBAC_MAP_SVH
// ==========================================================================
// register offsets of the controller's own register file
`define SBAC_REG_CTRL      4'h0
`define SBAC_REG_STATUS    4'h1
`define SBAC_REG_DLO       4'h2
`define SBAC_REG_DHI       4'h3
`define SBAC_REG_ECC       4'h4
`define SBAC_REG_CFG       4'h5
`define SBAC_REG_XFER      4'h6
// ==========================================================================
// control register bit positions
`define SBAC_CTRL_RESET    0
`define SBAC_CTRL_FLUSH    1
`define SBAC_CTRL_INIT     2
`define SBAC_CTRL_IGNORE_NUMERIC_ERROR    3
`define SBAC_CTRL_A20      4
`define SBAC_CTRL_INPUT_A    5
`define SBAC_CTRL_STALL    6
`define SBAC_CTRL_PRIO     7
`define SBAC_CTRL_BUS_INITIALISATION    8
`define SBAC_CTRL_LINT0    9
`define SBAC_CTRL_LINT1    10
`define SBAC_CTRL_RESET_VAL 11'h001
// ==========================================================================
// timing: minimum reset width and cycles between strap removal
`define SBAC_CLK_NS        50
`define SBAC_RST_MIN_NS    1000
`define SBAC_RST_CYC       ((`SBAC_RST_MIN_NS + `SBAC_CLK_NS - 1) / `SBAC_CLK_NS)
`define SBAC_STRAP_HOLD    2
`endif

// File: sbac_ctrl.sv
/*
  host-side controller of the processor system bus: drives reset with its
  power-on straps, owns request line 0 as central agent, moves data words
  with valid/busy strobes, defers, stalls snoops and gates priority on lock.
  assumes: one clock, synchronous reset, pins from the bus are asynchronous.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sbac_map.svh"

// ==========================================================================
// types
package sbac_pkg;
  typedef enum logic [2:0] {
    SBAC_RESET, SBAC_RELEASE, SBAC_RUN, SBAC_XFER, SBAC_GAP, SBAC_PRIO_WAIT, SBAC_PRIO_OWN
  } sbac_state_type;
endpackage : sbac_pkg

// Function
// - central agent drives request pin zero during reset
// - one-agent request wiring, lines one to three unused
// - data driver strobes valid on each word
// - data driver may idle between words
// - busy held while driving the data bus
// - responder asserts input_a for out-of-order completion
// - ecc bits travel with data, enabled by the cfg register
// - flush and ignore-error valid with target ready
// - both snoop results together request a stall
// - ratio straps follow the control bits in reset and after it
// - priority agent waits for lock release
// - all pins launched and captured on clk
module sbac_ctrl #(
  parameter int unsigned DATA_W = 64,
  parameter int unsigned ECC_W  = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // software register port
  input  wire logic [3:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  // device reset and straps (active low on the wire, except local_interrupt_inputs, which is active high)
  output logic                   reset_n,
  output logic                   flush_n,
  output logic                   soft_init_n,
  output logic                   ignore_numeric_error_n,
  output logic                   address_bit_mask_n,
  output logic      [1:0]        local_interrupt_inputs,
  output logic                   bus_initialisation_n,
  output logic                   input_a_n,
  output logic                   priority_bus_request_n,
  // own request pin, open drain
  output logic                   own_request_pin_o,
  output logic                   own_request_pin_oe,
  // data bus: input, output, enable
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe,
  input  wire logic [ECC_W-1:0]  data_ecc_bits_i,
  output logic      [ECC_W-1:0]  data_ecc_bits_o,
  input  wire logic              data_valid_strobe_i,
  output logic                   data_valid_strobe_o,
  input  wire logic              data_bus_busy_i,
  output logic                   data_bus_busy_o,
  output logic                   strobe_oe,
  // snoop stall pair, open drain
  output logic                   snoop_hit_o,
  output logic                   snoop_hit_modified_o,
  output logic                   snoop_oe,
  // device status inputs (active low)
  input  wire logic              lock_n,
  input  wire logic              fp_error_out_n,
  input  wire logic              internal_error_out_n
);
  localparam int unsigned RST_CYC = `SBAC_RST_CYC;

  typedef struct packed {
    sbac_pkg::sbac_state_type st;
    logic [10:0]       ctrl;
    logic [7:0]        cnt;
    logic [DATA_W-1:0] wdat;
    logic [ECC_W-1:0]  wecc;
    logic [7:0]        words;
    logic [7:0]        gap;
    logic [7:0]        left;
    logic [DATA_W-1:0] rdat;
    logic [ECC_W-1:0]  recc;
    logic [7:0]        rcnt;
    logic              ecc_en;
    logic [5:0]        s1;
    logic [5:0]        s2;
    logic              busy_seen;
    logic [31:0]       rdata;
  } sbac_regs_type;

  sbac_regs_type r, next_r;

  // synchronised asynchronous inputs: lock, fperr, internal_error_out, busy, valid
  logic [5:0] pins_async;
  assign pins_async = {1'b0, data_bus_busy_i, data_valid_strobe_i, lock_n, fp_error_out_n, internal_error_out_n};

  // next-state and register decode
  always_comb begin
    next_r       = r;
    next_r.s1    = pins_async;
    next_r.s2    = r.s1;
    next_r.rdata = 32'h0000_0000;
    // read path, one cycle latency
    if (rd) begin
      case (addr)
        `SBAC_REG_CTRL:   next_r.rdata = {21'h000000, r.ctrl};
        `SBAC_REG_STATUS: next_r.rdata = {24'h000000, r.rcnt[0], r.busy_seen, ~r.s2[2], ~r.s2[1], ~r.s2[0],
                                           r.st};
        `SBAC_REG_DLO:    next_r.rdata = r.rdat[31:0];
        `SBAC_REG_DHI:    next_r.rdata = r.rdat[63:32];
        `SBAC_REG_ECC:    next_r.rdata = {24'h000000, r.recc};
        `SBAC_REG_CFG:    next_r.rdata = {31'h00000000, r.ecc_en};
        `SBAC_REG_XFER:   next_r.rdata = {8'h00, r.rcnt, r.left, r.words};
        default:          next_r.rdata = 32'h0000_0000;
      endcase
    end
    // register writes
    if (wr) begin
      case (addr)
        `SBAC_REG_CTRL: next_r.ctrl = wdata[10:0];
        `SBAC_REG_DLO:  next_r.wdat[31:0] = wdata;
        `SBAC_REG_DHI:  next_r.wdat[63:32] = wdata;
        `SBAC_REG_ECC:  next_r.wecc = wdata[7:0];
        `SBAC_REG_CFG:  next_r.ecc_en = wdata[0];
        `SBAC_REG_XFER: begin
          next_r.words = wdata[7:0];
          next_r.gap   = wdata[15:8];
        end
        default: ;
      endcase
    end
    // capture words the device drives
    if (!r.s2[3] && r.st != sbac_pkg::SBAC_XFER) begin
      next_r.rdat = data_i;
      next_r.recc = data_ecc_bits_i;
      next_r.rcnt = r.rcnt + 8'h01;
    end
    if (!r.s2[4])
      next_r.busy_seen = 1'b1;
    // sequencer
    case (r.st)
      sbac_pkg::SBAC_RESET: begin
        if (r.cnt < RST_CYC[7:0])
          next_r.cnt = r.cnt + 8'h01;
        if (!r.ctrl[`SBAC_CTRL_RESET] && r.cnt >= RST_CYC[7:0]) begin
          next_r.st  = sbac_pkg::SBAC_RELEASE;
          next_r.cnt = 8'h00;
        end
      end
      sbac_pkg::SBAC_RELEASE: begin
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt == 8'(`SBAC_STRAP_HOLD - 1))
          next_r.st = sbac_pkg::SBAC_RUN;
      end
      sbac_pkg::SBAC_RUN: begin
        if (r.ctrl[`SBAC_CTRL_RESET]) begin
          next_r.st  = sbac_pkg::SBAC_RESET;
          next_r.cnt = 8'h00;
        end else if (wr && addr == `SBAC_REG_XFER && wdata[7:0] != 8'h00 && r.s2[4]) begin
          next_r.st   = sbac_pkg::SBAC_XFER;
          next_r.left = wdata[7:0];
        end else if (r.ctrl[`SBAC_CTRL_PRIO])
          next_r.st = sbac_pkg::SBAC_PRIO_WAIT;
      end
      sbac_pkg::SBAC_XFER: begin
        next_r.left = r.left - 8'h01;
        next_r.cnt  = 8'h00;
        if (r.left == 8'h01)
          next_r.st = sbac_pkg::SBAC_RUN;
        else if (r.gap != 8'h00)
          next_r.st = sbac_pkg::SBAC_GAP;
      end
      sbac_pkg::SBAC_GAP: begin
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt + 8'h01 >= r.gap)
          next_r.st = sbac_pkg::SBAC_XFER;
      end
      sbac_pkg::SBAC_PRIO_WAIT: begin
        if (!r.ctrl[`SBAC_CTRL_PRIO])
          next_r.st = sbac_pkg::SBAC_RUN;
        else if (r.s2[2])
          next_r.st = sbac_pkg::SBAC_PRIO_OWN;
      end
      sbac_pkg::SBAC_PRIO_OWN: begin
        if (!r.ctrl[`SBAC_CTRL_PRIO])
          next_r.st = sbac_pkg::SBAC_RUN;
      end
      default: next_r.st = sbac_pkg::SBAC_RESET;
    endcase
    if (srst) begin
      next_r       = '0;
      next_r.st    = sbac_pkg::SBAC_RESET;
      next_r.ctrl  = `SBAC_CTRL_RESET_VAL;
      next_r.s1    = 6'h3F;
      next_r.s2    = 6'h3F;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // pin drive; straps held through reset and its release window
  logic in_rst;
  logic driving;
  assign in_rst  = (r.st == sbac_pkg::SBAC_RESET) || (r.st == sbac_pkg::SBAC_RELEASE);
  assign driving = (r.st == sbac_pkg::SBAC_XFER) || (r.st == sbac_pkg::SBAC_GAP);

  always_comb begin
    reset_n                = ~(r.st == sbac_pkg::SBAC_RESET);
    own_request_pin_o      = 1'b0;
    own_request_pin_oe     = in_rst;
    flush_n                = ~r.ctrl[`SBAC_CTRL_FLUSH];
    soft_init_n            = ~r.ctrl[`SBAC_CTRL_INIT];
    ignore_numeric_error_n = ~r.ctrl[`SBAC_CTRL_IGNORE_NUMERIC_ERROR];
    address_bit_mask_n     = ~r.ctrl[`SBAC_CTRL_A20];
    local_interrupt_inputs = {r.ctrl[`SBAC_CTRL_LINT1], r.ctrl[`SBAC_CTRL_LINT0]};
    if (!in_rst && r.st != sbac_pkg::SBAC_RELEASE) begin
      ignore_numeric_error_n = ~r.ctrl[`SBAC_CTRL_IGNORE_NUMERIC_ERROR];
    end
    bus_initialisation_n   = ~r.ctrl[`SBAC_CTRL_BUS_INITIALISATION];
    input_a_n              = ~r.ctrl[`SBAC_CTRL_INPUT_A];
    priority_bus_request_n = ~((r.st == sbac_pkg::SBAC_PRIO_WAIT) || (r.st == sbac_pkg::SBAC_PRIO_OWN));
    data_o                 = r.wdat;
    data_ecc_bits_o        = r.ecc_en ? r.wecc : '0;
    data_oe                = (r.st == sbac_pkg::SBAC_XFER);
    data_valid_strobe_o    = ~(r.st == sbac_pkg::SBAC_XFER);
    data_bus_busy_o        = ~driving;
    strobe_oe              = driving;
    snoop_hit_o            = 1'b0;
    snoop_hit_modified_o   = 1'b0;
    snoop_oe               = r.ctrl[`SBAC_CTRL_STALL] && !in_rst;
  end

  assign rdata = r.rdata;

  // assertions
  property p_busy_span;
    @(posedge clk) disable iff (srst) (r.st == sbac_pkg::SBAC_XFER) |-> strobe_oe && !data_bus_busy_o;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy not held with data");

  property p_prio_lock;
    @(posedge clk) disable iff (srst)
      $rose(r.st == sbac_pkg::SBAC_PRIO_OWN) |-> $past(r.s2[2]);
  endproperty
  a_prio_lock: assert property (p_prio_lock) else $error("bus taken under lock");

  property p_id_strap;
    @(posedge clk) disable iff (srst) $rose(reset_n) |-> own_request_pin_oe ##2 !own_request_pin_oe;
  endproperty
  a_id_strap: assert property (p_id_strap) else $error("request pin strap not held");

  // a data word goes out with its valid strobe and the bus enabled
  sequence s_word_out;
    data_oe && !data_valid_strobe_o && strobe_oe;
  endsequence

  property p_word_strobe;
    @(posedge clk) disable iff (srst) (r.st == sbac_pkg::SBAC_XFER) |-> s_word_out;
  endproperty
  a_word_strobe: assert property (p_word_strobe) else $error("word sent without valid strobe");

  // idle cycles between words keep busy low and the strobe high
  property p_gap_idle;
    @(posedge clk) disable iff (srst)
      (r.st == sbac_pkg::SBAC_GAP) |-> !data_oe && data_valid_strobe_o && !data_bus_busy_o;
  endproperty
  a_gap_idle: assert property (p_gap_idle) else $error("gap cycle not idle");

  // request pin zero stays driven low across the release window
  property p_release_strap;
    @(posedge clk) disable iff (srst)
      (r.st == sbac_pkg::SBAC_RELEASE) |-> reset_n && own_request_pin_oe && !own_request_pin_o;
  endproperty
  a_release_strap: assert property (p_release_strap) else $error("strap dropped in release");

  // priority request stays asserted while the bus is owned
  property p_prio_hold;
    @(posedge clk) disable iff (srst) (r.st == sbac_pkg::SBAC_PRIO_OWN) |-> !priority_bus_request_n;
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("priority request dropped");
endmodule : sbac_ctrl
`default_nettype wire

// File: sbac_dev_model.sv
/* behavioural processor on the far side of the bus controller.
   assumes: bus pins active low, released lines pulled high. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// device model
module sbac_dev_model (
  // clock and pins from the controller
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       req0_n,
  input  wire logic       flush_n,
  input  wire logic       soft_init_n,
  input  wire logic       bus_initialisation_n,
  // bench commands
  input  wire logic       lock_cmd,
  input  wire logic       busy_cmd,
  input  wire logic       fp_cmd,
  input  wire logic       internal_error_out_cmd,
  // device pins and latched straps
  output logic            lock_n,
  output logic            fp_error_out_n,
  output var logic        internal_error_out_n,
  output logic            busy_n,
  output var logic  [1:0] agent_id,
  output var logic        self_test,
  output var logic        flush_cfg
);
  logic rst_q;
  // straps latched on reset release, internal error held until cleared
  always_ff @(posedge clk) begin
    rst_q <= reset_n;
    if (reset_n && !rst_q) begin
      case ({3'h7, req0_n}) // pins 1..3 unconnected, pulled high
        4'hE: agent_id <= 2'h0;
        4'h7: agent_id <= 2'h1;
        4'hB: agent_id <= 2'h2;
        default: agent_id <= 2'h3;
      endcase
      flush_cfg <= !flush_n;
      self_test <= !soft_init_n;
    end
    if (!reset_n || !bus_initialisation_n || !soft_init_n) internal_error_out_n <= 1'b1;
    else if (internal_error_out_cmd) internal_error_out_n <= 1'b0;
  end
  // level outputs commanded by the bench
  assign fp_error_out_n = !fp_cmd;
  assign lock_n         = !lock_cmd;
  assign busy_n         = !busy_cmd;
endmodule : sbac_dev_model
`default_nettype wire

// File: tb_sysbus_agent_signal_ctrl.sv
/* self-checking bench of the bus controller with a device model.
   assumes: design and model compiled first, register map header. */
`timescale 1ns/1ps
`default_nettype none
`include "sbac_map.svh"
// ==========================================================================
// bench top
module tb_sysbus_agent_signal_ctrl;
  logic clk, srst, wr, rd, reset_n, flush_n, soft_init_n, ignore_numeric_error_n;
  logic address_bit_mask_n, bus_initialisation_n, input_a_n, priority_bus_request_n;
  logic own_request_pin_o, own_request_pin_oe, data_oe, data_valid_strobe_i, data_valid_strobe_o;
  logic data_bus_busy_i, data_bus_busy_o, strobe_oe, snoop_hit_o, snoop_hit_modified_o, snoop_oe;
  logic lock_n, fp_error_out_n, internal_error_out_n, req0_n, dev_busy_n, self_test, flush_cfg;
  logic lock_cmd, busy_cmd, fp_cmd, internal_error_out_cmd;
  logic [1:0]  local_interrupt_inputs, agent_id;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic [63:0] data_i, data_o;
  logic [7:0]  data_ecc_bits_i, data_ecc_bits_o;
  int          failures = 0;
  int          tests_run = 0;
  // wire levels: released lines pulled high
  assign req0_n              = own_request_pin_oe ? own_request_pin_o : 1'b1;
  assign data_i              = data_oe ? data_o : '1;
  assign data_ecc_bits_i     = data_oe ? data_ecc_bits_o : '1;
  assign data_valid_strobe_i = strobe_oe ? data_valid_strobe_o : 1'b1;
  assign data_bus_busy_i     = (strobe_oe ? data_bus_busy_o : 1'b1) & dev_busy_n;
  always #25 clk = !clk;
  sbac_ctrl sbac_ctrl_i (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .reset_n, .flush_n,
    .soft_init_n, .ignore_numeric_error_n, .address_bit_mask_n, .local_interrupt_inputs,
    .bus_initialisation_n, .input_a_n, .priority_bus_request_n, .own_request_pin_o,
    .own_request_pin_oe, .data_i, .data_o, .data_oe, .data_ecc_bits_i, .data_ecc_bits_o,
    .data_valid_strobe_i, .data_valid_strobe_o, .data_bus_busy_i, .data_bus_busy_o, .strobe_oe,
    .snoop_hit_o, .snoop_hit_modified_o, .snoop_oe, .lock_n, .fp_error_out_n, .internal_error_out_n);
  sbac_dev_model sbac_dev_model_i (.clk, .reset_n, .req0_n, .flush_n, .soft_init_n,
    .bus_initialisation_n, .lock_cmd, .busy_cmd, .fp_cmd, .internal_error_out_cmd, .lock_n, .fp_error_out_n,
    .internal_error_out_n, .busy_n(dev_busy_n), .agent_id, .self_test, .flush_cfg);
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0; #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0; #1;
    d = rdata;
  endtask : rd_reg
  task automatic conclude;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    rd_reg(`SBAC_REG_CTRL, d); chk(d, `SBAC_CTRL_RESET_VAL);
    rd_reg(4'hF, d); chk(d, 0);
    chk({reset_n, req0_n}, 2'h0);
    wr_reg(`SBAC_REG_CTRL, 32'h6); // flush and init straps, reset released
    for (int n = 0; n < 60 && reset_n !== 1'b1; n++) @(posedge clk);
    repeat (4) @(posedge clk); #1;
    chk({reset_n, agent_id}, 3'h4);
    chk({self_test, flush_cfg}, 2'h3);
    wr_reg(`SBAC_REG_CTRL, 32'h0);
  endtask : t_reset
  task automatic t_pins;
    logic [10:0] v;
    for (int i = 3; i <= 10; i++) if (i != 7) begin
      wr_reg(`SBAC_REG_CTRL, 32'h1 << i);
      @(posedge clk); #1;
      v = {local_interrupt_inputs, !bus_initialisation_n, 1'b0, snoop_oe & !snoop_hit_o &
           !snoop_hit_modified_o, !input_a_n, !address_bit_mask_n, !ignore_numeric_error_n, 3'h0};
      chk(v, 11'h1 << i);
    end
    wr_reg(`SBAC_REG_CTRL, 32'h0);
  endtask : t_pins
  // sends two words one idle apart and counts strobe cycles
  task automatic xfer_watch(input int nv_e, input int nb_e);
    int nv = 0;
    int nb = 0;
    wr_reg(`SBAC_REG_XFER, 32'h0102);
    repeat (20) begin
      if (data_valid_strobe_o === 1'b0) begin
        nv++;
        chk({data_oe, strobe_oe, data_bus_busy_o}, 3'h6);
        chk(data_o, 64'h0123456789ABCDEF);
        chk(data_ecc_bits_o, 8'h5A);
      end
      if (data_bus_busy_o === 1'b0) nb++;
      @(posedge clk); #1;
    end
    chk(nv, nv_e);
    chk(nb, nb_e);
  endtask : xfer_watch
  task automatic t_xfer;
    wr_reg(`SBAC_REG_DLO, 32'h89ABCDEF);
    wr_reg(`SBAC_REG_DHI, 32'h01234567);
    wr_reg(`SBAC_REG_ECC, 32'h5A);
    wr_reg(`SBAC_REG_CFG, 32'h1);
    xfer_watch(2, 3);
  endtask : t_xfer
  task automatic t_refuse;
    busy_cmd <= 1'b1;
    repeat (4) @(posedge clk);
    xfer_watch(0, 0);
    busy_cmd <= 1'b0;
  endtask : t_refuse
  task automatic t_prio;
    logic [31:0] d;
    lock_cmd <= 1'b1;
    wr_reg(`SBAC_REG_CTRL, 32'h80);
    repeat (4) @(posedge clk);
    rd_reg(`SBAC_REG_STATUS, d);
    chk({priority_bus_request_n, d[5], d[2:0]}, {2'h1, sbac_pkg::SBAC_PRIO_WAIT});
    lock_cmd <= 1'b0;
    repeat (6) @(posedge clk);
    rd_reg(`SBAC_REG_STATUS, d);
    chk({d[5], d[2:0]}, {1'b0, sbac_pkg::SBAC_PRIO_OWN});
    wr_reg(`SBAC_REG_CTRL, 32'h0);
  endtask : t_prio
  task automatic t_err;
    logic [31:0] d;
    fp_cmd <= 1'b1; internal_error_out_cmd <= 1'b1;
    @(posedge clk); internal_error_out_cmd <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(`SBAC_REG_STATUS, d); chk(d[4:3], 2'h3);
    fp_cmd <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(`SBAC_REG_STATUS, d); chk(d[4:3], 2'h1);
    wr_reg(`SBAC_REG_CTRL, 32'h4);
    repeat (4) @(posedge clk);
    rd_reg(`SBAC_REG_STATUS, d); chk(d[3], 1'b0);
    wr_reg(`SBAC_REG_CTRL, 32'h0);
  endtask : t_err
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    {clk, addr, wdata, wr, rd, lock_cmd, busy_cmd, fp_cmd, internal_error_out_cmd} = '0;
    srst = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset; t_pins; t_xfer; t_refuse; t_prio; t_err;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    conclude;
  end
endmodule : tb_sysbus_agent_signal_ctrl
`default_nettype wire
